// >>> inc/uvf_pkg.sv
package uvf_pkg;
  localparam logic [7:0] UVF_CMD_CODE = 8'h45;
  localparam int UVF_BIT_ZERO = 7;
  localparam int UVF_BIT_EN_N = 6;
  localparam int UVF_RS_HI = 5;
  localparam int UVF_RS_LO = 3;
  localparam int UVF_TD_HI = 2;
  localparam logic UVF_EN_N_RESET = 1'b1;
  localparam logic [2:0] UVF_TD_RESET = 3'h0;
  localparam logic [2:0] UVF_RS_LATCH = 3'h0;
  localparam logic [2:0] UVF_RS_HICCUP = 3'h7;
  localparam int UVF_CLK_MHZ = 100;
  localparam int UVF_TD0_US = 2;
  localparam int UVF_TD1_US = 16;
  localparam int UVF_TD2_US = 64;
  localparam int UVF_TD3_US = 256;
  localparam int UVF_HICCUP_MS = 52;
  localparam int UVF_TD0_CYC = UVF_TD0_US * UVF_CLK_MHZ;
  localparam int UVF_TD1_CYC = UVF_TD1_US * UVF_CLK_MHZ;
  localparam int UVF_TD2_CYC = UVF_TD2_US * UVF_CLK_MHZ;
  localparam int UVF_TD3_CYC = UVF_TD3_US * UVF_CLK_MHZ;
  localparam int UVF_HICCUP_CYC = UVF_HICCUP_MS * 1000 * UVF_CLK_MHZ;

  typedef enum logic [1:0] {
    UVF_RUN = 2'b00,
    UVF_WAIT = 2'b01,
    UVF_HICCUP = 2'b11,
    UVF_LATCHED = 2'b10
  } uvf_state_t;

  typedef struct packed {
    logic output_undervolt_flag;
    logic output_voltage_summary_flag;
    logic output_voltage_status_uv;
  } uvf_status_t;
endpackage : uvf_pkg

// >>> hw/uvf_response.sv
`timescale 1ns/1ps
// undervoltage fault response with its command byte
module uvf_response #(
  parameter int HICCUP_CYC = uvf_pkg::UVF_HICCUP_CYC,
  parameter int TD3_CYC = uvf_pkg::UVF_TD3_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_stb,
  input wire logic [7:0] wr_cmd,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_cmd,
  input wire logic nvm_restore,
  input wire logic nvm_rs_bit,
  input wire logic uv_compare,
  input wire logic soft_start_done,
  input wire logic clear_faults,
  input wire logic enable_toggle,
  output logic wr_nack,
  output logic invalid_data,
  output logic [7:0] rd_data,
  output uvf_pkg::uvf_status_t status,
  output logic smbalert_n,
  output logic conv_enable,
  output logic nvm_rs_store
);
  // counter must span the longest interval, hiccup or slowest delay
  localparam int MAX_CYC = (HICCUP_CYC > TD3_CYC) ? HICCUP_CYC : TD3_CYC;
  localparam int CW = $clog2(MAX_CYC + 1);

  logic uv_respond_enable_n_r;
  logic [2:0] uv_retry_select_r;
  logic [1:0] uv_response_delay_r;
  logic fault_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] delay_cyc;
  logic [7:0] reg_value;
  logic hit;
  logic bad;
  logic uv_live;
  logic [2:0] wr_rs_field; // retry bits of the written byte
  logic [1:0] wr_td_field; // writable delay bits
  logic wr_en_n_bit;
  logic rs_legal;
  logic en_q_r; // enable bit one cycle ago
  logic en_rise;
  logic pend_r; // earlier ignored fault now being answered
  logic abort_wait;
  uvf_pkg::uvf_state_t state_r;

  // refuse counts that the counter or the delay ladder cannot serve
  initial begin
    if (HICCUP_CYC < 2) begin
      $error("uvf_response: hiccup count too small");
    end
    if (TD3_CYC < uvf_pkg::UVF_TD2_CYC) begin
      $error("uvf_response: slowest delay below the third step");
    end
    if (CW > 32) begin
      $error("uvf_response: counter wider than 32 bits");
    end
  end

  assign hit = wr_stb && (wr_cmd == uvf_pkg::UVF_CMD_CODE);
  // split the written byte into its fields
  assign wr_rs_field = wr_data[uvf_pkg::UVF_RS_HI:uvf_pkg::UVF_RS_LO];
  assign wr_td_field = wr_data[uvf_pkg::UVF_TD_HI-1:0];
  assign wr_en_n_bit = wr_data[uvf_pkg::UVF_BIT_EN_N];
  // only all-zero or all-one retry fields are served
  assign rs_legal = (wr_rs_field == uvf_pkg::UVF_RS_LATCH) ||
    (wr_rs_field == uvf_pkg::UVF_RS_HICCUP);
  // reject a set bit 7 or a mixed retry field
  assign bad = wr_data[uvf_pkg::UVF_BIT_ZERO] || !rs_legal;
  assign uv_live = uv_compare && soft_start_done;
  assign reg_value = {1'b0, uv_respond_enable_n_r, uv_retry_select_r, 1'b0,
    uv_response_delay_r};
  assign nvm_rs_store = uv_retry_select_r[2];

  // delay code to cycle count
  always_comb begin
    unique case (uv_response_delay_r)
      2'h0: delay_cyc = CW'(uvf_pkg::UVF_TD0_CYC);
      2'h1: delay_cyc = CW'(uvf_pkg::UVF_TD1_CYC);
      2'h2: delay_cyc = CW'(uvf_pkg::UVF_TD2_CYC);
      2'h3: delay_cyc = CW'(TD3_CYC);
    endcase
  end

  // respond-enable bit, live update
  always_ff @(posedge clk) begin
    if (rst) begin
      uv_respond_enable_n_r <= uvf_pkg::UVF_EN_N_RESET;
    end else if (hit && !bad) begin
      uv_respond_enable_n_r <= wr_en_n_bit;
    end
  end

  // retry bits: restore from storage wins over a host write
  always_ff @(posedge clk) begin
    if (rst) begin
      uv_retry_select_r <= uvf_pkg::UVF_RS_LATCH;
    end else if (nvm_restore) begin
      uv_retry_select_r <= {3{nvm_rs_bit}};
    end else if (hit && !bad) begin
      uv_retry_select_r <= wr_rs_field;
    end
  end

  // delay bits; the read-only top bit of the field is never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      uv_response_delay_r <= uvf_pkg::UVF_TD_RESET[1:0];
    end else if (hit && !bad) begin
      uv_response_delay_r <= wr_td_field;
    end
  end

  // write answer and invalid-data flag
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_nack <= 1'b0;
      invalid_data <= 1'b0;
    end else begin
      wr_nack <= hit && bad;
      if (hit && bad) begin
        invalid_data <= 1'b1;
      end else if (clear_faults) begin
        invalid_data <= 1'b0;
      end
    end
  end

  // read data
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= (rd_cmd == uvf_pkg::UVF_CMD_CODE) ? reg_value : 8'h00;
    end
  end

  // sticky fault status, set beats clear
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_r <= 1'b0;
    end else if (uv_live) begin
      fault_r <= 1'b1;
    end else if (clear_faults) begin
      fault_r <= 1'b0;
    end
  end
  assign status = '{fault_r, fault_r, fault_r};
  assign smbalert_n = !fault_r;

  // enable bit edge; reset value matches the bit's own so no false edge
  always_ff @(posedge clk) begin
    if (rst) begin
      en_q_r <= uvf_pkg::UVF_EN_N_RESET;
    end else begin
      en_q_r <= uv_respond_enable_n_r;
    end
  end
  assign en_rise = uv_respond_enable_n_r && !en_q_r;

  // a fault kept while ignored is answered once responses are enabled
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r <= 1'b0;
    end else if (!uv_respond_enable_n_r || clear_faults) begin
      pend_r <= 1'b0;
    end else if (state_r == uvf_pkg::UVF_RUN && en_rise && fault_r) begin
      pend_r <= 1'b1;
    end else if (state_r != uvf_pkg::UVF_WAIT && state_r != uvf_pkg::UVF_RUN) begin
      pend_r <= 1'b0;
    end
  end
  // the wait ends early once the live fault and any pending one are gone
  assign abort_wait = !uv_live && !pend_r;

  // response sequencer with delay and hiccup counter
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= uvf_pkg::UVF_RUN;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        uvf_pkg::UVF_RUN: begin
          cnt_r <= '0;
          // live fault, or an earlier ignored one when responses turn on
          if (uv_respond_enable_n_r && (uv_live || (en_rise && fault_r))) begin
            state_r <= uvf_pkg::UVF_WAIT;
          end
        end
        uvf_pkg::UVF_WAIT: begin
          if (!uv_respond_enable_n_r) begin
            state_r <= uvf_pkg::UVF_RUN;
          end else if (abort_wait) begin
            state_r <= uvf_pkg::UVF_RUN;
            cnt_r <= '0;
          end else if (cnt_r + 1'b1 >= delay_cyc) begin
            cnt_r <= '0;
            state_r <= (uv_retry_select_r == uvf_pkg::UVF_RS_HICCUP) ?
              uvf_pkg::UVF_HICCUP : uvf_pkg::UVF_LATCHED;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        uvf_pkg::UVF_HICCUP: begin
          if (cnt_r + 1'b1 >= CW'(HICCUP_CYC)) begin
            cnt_r <= '0;
            state_r <= uvf_pkg::UVF_RUN;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        uvf_pkg::UVF_LATCHED: begin
          if (enable_toggle) begin
            state_r <= uvf_pkg::UVF_RUN;
          end
        end
      endcase
    end
  end
  assign conv_enable = (state_r == uvf_pkg::UVF_RUN) || (state_r == uvf_pkg::UVF_WAIT);
endmodule : uvf_response

// >>> verif/uvf_response_monitor.sv
`timescale 1ns/1ps
module uvf_response_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_stb,
  input wire logic [7:0] wr_cmd,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_cmd,
  input wire logic [7:0] rd_data,
  input wire logic wr_nack,
  input wire uvf_pkg::uvf_status_t status,
  input wire logic smbalert_n,
  input wire logic conv_enable,
  input wire logic invalid_data,
  input wire logic nvm_restore,
  input wire logic nvm_rs_bit,
  input wire logic nvm_rs_store,
  input wire logic uv_compare,
  input wire logic soft_start_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // byte write to the response command, and a retry field with unequal bits
  wire w45 = wr_stb && wr_cmd == 8'h45;
  wire odd = wr_data[5:3] != {3{wr_data[5]}};
  a_nack_bit7: assert property (w45 && wr_data[7] |=> wr_nack) else $error("nack");
  a_bad_retry: assert property (w45 && odd |=> wr_nack) else $error("nack");
  a_take_good: assert property (w45 && !wr_data[7] && !odd |=> !wr_nack) else $error("nack");
  a_read_zero: assert property (rd_cmd == 8'h45 |=> !rd_data[7] && !rd_data[2]) else $error("rd");
  a_read_other: assert property (rd_cmd != 8'h45 |=> rd_data == 8'h00) else $error("rd");
  a_alert_flags: assert property ($fell(smbalert_n) |-> status == 3'h7) else $error("flags");
  a_delay_run: assert property ($fell(smbalert_n) && conv_enable |-> conv_enable [*8]) else $error("off");
  a_soft_gate: assert property ($fell(smbalert_n) |-> $past(uv_compare) && $past(soft_start_done)) else $error("gate");
  a_restore_copy: assert property (nvm_restore |=> nvm_rs_store == $past(nvm_rs_bit)) else $error("nvm");
  a_nack_flag: assert property (wr_nack |-> invalid_data) else $error("ivd");
  a_off_cause: assert property ($fell(conv_enable) |-> !smbalert_n) else $error("off");
endmodule : uvf_response_monitor

// >>> verif/uvf_host.sv
`timescale 1ns/1ps
module uvf_host (
  input wire logic clk,
  input wire logic [7:0] rd_data,
  output logic wr_stb = 1'b0,
  output logic [7:0] wr_cmd = 8'h45,
  output logic [7:0] wr_data = 8'h00,
  output logic [7:0] rd_cmd = 8'hBA
);
  // write byte: one-cycle strobe; read byte: data two edges after the command
  task wr(input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task rd(output logic [7:0] q);
    @(posedge clk);
    rd_cmd <= 8'h45;
    repeat (2) @(posedge clk);
    q = rd_data;
  endtask : rd
endmodule : uvf_host

// >>> verif/uvf_response_test.sv
`timescale 1ns/1ps
module uvf_response_test;
  logic clk = 1'b0, rst = 1'b1, uv_compare = 1'b0, clear_faults = 1'b0, enable_toggle = 1'b0;
  logic nvm_restore = 1'b0, nvm_rs_bit = 1'b0, soft_start_done = 1'b0;
  logic wr_stb, wr_nack, invalid_data, smbalert_n, conv_enable, nvm_rs_store;
  logic [7:0] wr_cmd, wr_data, rd_cmd, rd_data, q;
  uvf_pkg::uvf_status_t status;
  int err_total = 0, checked = 0;
  uvf_response #(.HICCUP_CYC(50), .TD3_CYC(6400)) i_dut (.*);
  uvf_host i_host (.*);
  // free-running clock
  initial forever #5 clk = ~clk;
  // count a compare, report a miss
  task chk(input logic [7:0] s, e);
    checked++;
    err_total += (s !== e);
    if (s !== e) $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
  endtask : chk
  // counts, verdict, end of run
  task stop_test;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // wait n edges, then look at the enable between edges
  task hold(input int n, input logic e);
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk(8'(conv_enable), 8'(e));
  endtask : hold
  // one-cycle clear pulse launched on a rising edge
  task clear_pulse;
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
    @(negedge clk);
  endtask : clear_pulse
  // reset values, register access, soft-start gate, responses, mid-run reset
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({smbalert_n, conv_enable, wr_nack, invalid_data, nvm_rs_store, status}, 8'hC0);
    i_host.rd(q);
    chk(q, 8'h40);
    @(posedge clk);
    nvm_restore <= 1'b1;
    nvm_rs_bit <= 1'b1;
    @(posedge clk);
    nvm_restore <= 1'b0;
    @(negedge clk);
    chk(8'(nvm_rs_store), 8'h01);
    i_host.rd(q);
    chk(q, 8'h78);
    i_host.wr(8'hD0);
    @(negedge clk);
    chk(8'(wr_nack), 8'h01);
    chk(8'(invalid_data), 8'h01);
    i_host.rd(q);
    chk(q, 8'h78);
    clear_pulse();
    chk(8'(invalid_data), 8'h00);
    i_host.wr(8'h28);
    @(negedge clk);
    chk(8'(wr_nack), 8'h01);
    i_host.wr(8'h7F);
    @(negedge clk);
    chk(8'(wr_nack), 8'h00);
    i_host.rd(q);
    chk(q, 8'h7B);
    $display("test register access done");
    i_host.wr(8'h38);
    @(posedge clk);
    uv_compare <= 1'b1;
    hold(20, 1'b1);
    chk(8'(smbalert_n), 8'h01);
    @(posedge clk);
    soft_start_done <= 1'b1;
    hold(300, 1'b1);
    chk(8'(status), 8'h07);
    chk(8'(smbalert_n), 8'h00);
    i_host.wr(8'h78);
    hold(190, 1'b1);
    hold(40, 1'b0);
    hold(70, 1'b1);
    @(posedge clk);
    uv_compare <= 1'b0;
    hold(400, 1'b1);
    @(posedge clk);
    uv_compare <= 1'b1;
    i_host.wr(8'h40);
    hold(400, 1'b0);
    @(posedge clk);
    uv_compare <= 1'b0;
    clear_faults <= 1'b1;
    enable_toggle <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
    enable_toggle <= 1'b0;
    @(negedge clk);
    chk(8'(conv_enable), 8'h01);
    chk(8'(smbalert_n), 8'h01);
    $display("test fault response done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(8'(conv_enable), 8'h01);
    i_host.rd(q);
    chk(q, 8'h40);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : uvf_response_test
bind uvf_response uvf_response_monitor i_mon (.*);
